// ---- inc/t8_pkg.sv ----
// package for the 8-bit timer/counter core: map, fields, modes
package t8_pkg;
  localparam logic [7:0] IO_OFFSET = 8'h20;
  localparam logic [7:0] EXT_IO_BASE = 8'h60;
  localparam logic [7:0] ADDR_FLAGS = 8'h35;
  localparam logic [7:0] ADDR_COUNT = 8'h46;
  localparam logic [7:0] ADDR_CMP_A = 8'h47;
  localparam logic [7:0] ADDR_CMP_B = 8'h48;
  localparam logic [7:0] ADDR_MASK = 8'h6E;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hFF;
  localparam int BIT_OVF = 0;
  localparam int BIT_MATCH_A = 1;
  localparam int BIT_MATCH_B = 2;
  localparam int NUM_FLAGS = 3;

  typedef enum logic [2:0] {
    WGM_NORMAL = 3'h0,
    WGM_PC_MAX = 3'h1,
    WGM_CTC = 3'h2,
    WGM_FAST_MAX = 3'h3,
    WGM_RSVD4 = 3'h4,
    WGM_PC_CMPA = 3'h5,
    WGM_RSVD6 = 3'h6,
    WGM_FAST_CMPA = 3'h7
  } t8_wgm_t;

  typedef struct packed {
    logic data_space;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } t8_bus_t;
endpackage : t8_pkg

// ---- design/t8_core.sv ----
// 8-bit timer/counter core: count, compares, flags, mask and interrupt requests
// How it works
// - registers answer at offset, and below 0x60 also at offset minus 0x20
// - counter readable, writable, loads immediately, resets zero
// - counter write blocks match on next tick
// - compare A checked against counter every cycle
// - compare B checked against counter every cycle
// - B equality sets flag bit 2
// - A equality sets flag bit 1
// - overflow sets flag bit 0, mode dependent
// - vector entry clears the matching flag
// - writing one clears flag, zero keeps
// - request needs flag, enable and global enable
// - BOTTOM is count zero
// - MAX is count 0xFF
// - TOP is MAX or compare A by mode
// - mask bits 0..2 at 0x6E, reset zero
// - forced compare moves output in non-pwm modes, sets no flag
`timescale 1ns/100ps
`default_nettype none
module t8_core (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire t8_pkg::t8_bus_t bus_i,
  input wire logic tick_i,
  input wire t8_pkg::t8_wgm_t waveform_mode_sel_i,
  input wire logic force_match_a_strobe_i,
  input wire logic force_match_b_strobe_i,
  input wire logic global_int_enable_i,
  input wire logic [2:0] int_ack_i,
  output logic [7:0] rdata_o,
  output logic [2:0] int_req_o,
  output logic match_a_o,
  output logic match_b_o,
  output logic wave_out_a_o,
  output logic wave_out_b_o
);
  import t8_pkg::*;

  logic [7:0] counter_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [2:0] timer_flag_register;
  logic [2:0] timer_mask_register;
  logic block_match;
  logic count_down;

  // io-space accesses come in 0x20 lower; only the low map fits there
  wire [7:0] eff_addr = bus_i.data_space ? bus_i.addr : bus_i.addr + IO_OFFSET;
  wire io_ok = bus_i.data_space || (bus_i.addr < IO_OFFSET + IO_OFFSET);
  wire ext_ok = bus_i.data_space || (eff_addr < EXT_IO_BASE);
  wire acc_ok = io_ok && ext_ok;
  wire sel_flags = acc_ok && eff_addr == ADDR_FLAGS;
  wire sel_count = acc_ok && eff_addr == ADDR_COUNT;
  wire sel_cmp_a = acc_ok && eff_addr == ADDR_CMP_A;
  wire sel_cmp_b = acc_ok && eff_addr == ADDR_CMP_B;
  wire sel_mask = acc_ok && eff_addr == ADDR_MASK;
  wire wr_count = bus_i.wr && sel_count;

  wire mode_cmpa_top = waveform_mode_sel_i == WGM_CTC || waveform_mode_sel_i == WGM_PC_CMPA ||
                       waveform_mode_sel_i == WGM_FAST_CMPA;
  wire [7:0] top_value = mode_cmpa_top ? compare_value_a : MAX;
  wire phase_correct = waveform_mode_sel_i == WGM_PC_MAX || waveform_mode_sel_i == WGM_PC_CMPA;
  wire fast_pwm = waveform_mode_sel_i == WGM_FAST_MAX || waveform_mode_sel_i == WGM_FAST_CMPA;
  wire at_top = counter_value == top_value;
  wire at_bottom = counter_value == BOTTOM;
  wire at_max = counter_value == MAX;

  // compares run continuously; the tick only qualifies the flag event
  wire eq_a = counter_value == compare_value_a;
  wire eq_b = counter_value == compare_value_b;
  wire match_a_evt = tick_i && eq_a && !block_match && !wr_count;
  wire match_b_evt = tick_i && eq_b && !block_match && !wr_count;

  // overflow point per mode: max in normal and ctc, top in fast pwm, bottom in phase correct
  wire ovf_point = phase_correct ? (at_bottom && count_down) :
                   fast_pwm ? at_top : at_max;
  wire ovf_evt = tick_i && !wr_count && ovf_point;

  // turn at the ends so the counter never steps below bottom, or past top unless top is zero
  wire step_down = (at_top && top_value != BOTTOM) ? 1'b1 : at_bottom ? 1'b0 : count_down;
  wire [7:0] next_count = wr_count ? bus_i.wdata :
                          !tick_i ? counter_value :
                          phase_correct ? (step_down ? counter_value - 8'h01 : counter_value + 8'h01) :
                          at_top ? BOTTOM : counter_value + 8'h01;
  wire next_down = !phase_correct ? 1'b0 :
                   (tick_i && !wr_count) ? step_down : count_down;

  wire [2:0] set_evt = {match_b_evt, match_a_evt, ovf_evt};
  wire [2:0] w1c = (bus_i.wr && sel_flags) ? bus_i.wdata[2:0] : 3'h0;
  wire [2:0] next_flags;
  genvar flag_idx;
  for (flag_idx = 0; flag_idx < NUM_FLAGS; flag_idx++) begin : g_flag
    // set wins over a clear landing in the same cycle
    assign next_flags[flag_idx] = set_evt[flag_idx] |
                                  (timer_flag_register[flag_idx] & ~w1c[flag_idx] & ~int_ack_i[flag_idx]);

    flag_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      set_evt[flag_idx] |=> timer_flag_register[flag_idx])
      else $error("flag not set on event");

    flag_w1c_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (w1c[flag_idx] && !set_evt[flag_idx]) |=> !timer_flag_register[flag_idx])
      else $error("write one did not clear flag");

    flag_ack_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (int_ack_i[flag_idx] && !set_evt[flag_idx]) |=> !timer_flag_register[flag_idx])
      else $error("ack did not clear flag");

    flag_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!set_evt[flag_idx] && !w1c[flag_idx] && !int_ack_i[flag_idx]) |=>
      timer_flag_register[flag_idx] == $past(timer_flag_register[flag_idx])) else $error("flag changed alone");

    flag_rise_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(timer_flag_register[flag_idx]) |-> $past(set_evt[flag_idx]))
      else $error("flag rose without event");

    req_full_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      int_req_o[flag_idx] == (timer_flag_register[flag_idx] && $past(timer_mask_register[flag_idx]) &&
      $past(global_int_enable_i))) else $error("request not flag and enables");
  end
  wire [2:0] next_req = next_flags & timer_mask_register & {NUM_FLAGS{global_int_enable_i}};

  wire [7:0] next_rdata = !bus_i.rd ? RESET_VALUE :
                          sel_count ? counter_value :
                          sel_cmp_a ? compare_value_a :
                          sel_cmp_b ? compare_value_b :
                          sel_flags ? {5'h00, timer_flag_register} :
                          sel_mask ? {5'h00, timer_mask_register} : RESET_VALUE;

  // force only acts in non-pwm modes and never touches the flags
  wire non_pwm = !phase_correct && !fast_pwm;
  wire tog_a = match_a_evt || (force_match_a_strobe_i && non_pwm);
  wire tog_b = match_b_evt || (force_match_b_strobe_i && non_pwm);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      counter_value <= RESET_VALUE;
      compare_value_a <= RESET_VALUE;
      compare_value_b <= RESET_VALUE;
      timer_mask_register <= 3'h0;
      timer_flag_register <= 3'h0;
      block_match <= 1'b0;
      count_down <= 1'b0;
    end else begin
      counter_value <= next_count;
      count_down <= next_down;
      if (bus_i.wr && sel_cmp_a) compare_value_a <= bus_i.wdata;
      if (bus_i.wr && sel_cmp_b) compare_value_b <= bus_i.wdata;
      if (bus_i.wr && sel_mask) timer_mask_register <= bus_i.wdata[2:0];
      timer_flag_register <= next_flags;
      // hold the block until the first tick after the write
      block_match <= wr_count | (block_match & ~tick_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= RESET_VALUE;
      int_req_o <= 3'h0;
      match_a_o <= 1'b0;
      match_b_o <= 1'b0;
      wave_out_a_o <= 1'b0;
      wave_out_b_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      int_req_o <= next_req;
      match_a_o <= match_a_evt;
      match_b_o <= match_b_evt;
      wave_out_a_o <= wave_out_a_o ^ tog_a;
      wave_out_b_o <= wave_out_b_o ^ tog_b;
    end
  end

  match_sets_b_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    match_b_evt |=> timer_flag_register[BIT_MATCH_B]) else $error("match b flag not set");
  match_sets_a_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    match_a_evt |=> timer_flag_register[BIT_MATCH_A]) else $error("match a flag not set");
  ovf_sets_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ovf_evt |=> timer_flag_register[BIT_OVF]) else $error("overflow flag not set");
  w1c_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.wr && sel_flags && bus_i.wdata[BIT_OVF] && !ovf_evt) |=> !timer_flag_register[BIT_OVF])
    else $error("write one did not clear");
  ack_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (int_ack_i[BIT_MATCH_A] && !match_a_evt) |=> !timer_flag_register[BIT_MATCH_A])
    else $error("ack did not clear flag");
  count_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_count |=> counter_value == $past(bus_i.wdata)) else $error("count not loaded");
  write_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_count ##1 (!tick_i)[*1] ##1 tick_i |-> !match_a_evt) else $error("match after write");
  req_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    int_req_o[BIT_OVF] |-> $past(global_int_enable_i) && $past(timer_mask_register[BIT_OVF]))
    else $error("request without enables");
  set_wins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (match_b_evt && w1c[BIT_MATCH_B]) |=> timer_flag_register[BIT_MATCH_B])
    else $error("set lost to clear");

  count_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!tick_i && !wr_count) |=> $stable(counter_value))
    else $error("count moved without tick");

  count_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tick_i && !wr_count && !phase_correct && !at_top) |=> counter_value == $past(counter_value) + 8'h01)
    else $error("count did not step up");

  count_wrap_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tick_i && !wr_count && !phase_correct && at_top) |=> counter_value == BOTTOM)
    else $error("count did not wrap at top");

  pc_turn_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tick_i && !wr_count && phase_correct && at_top && top_value != BOTTOM) |=> counter_value == $past(counter_value) - 8'h01)
    else $error("no turn at top");

  pc_rise_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tick_i && !wr_count && phase_correct && at_bottom) |=> counter_value == 8'h01)
    else $error("no turn at bottom");

  ovf_norm_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ovf_evt && !phase_correct && !fast_pwm) |-> at_max)
    else $error("overflow away from max");

  ovf_fast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ovf_evt && fast_pwm) |-> at_top)
    else $error("fast overflow away from top");

  ovf_pc_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ovf_evt && phase_correct) |-> at_bottom)
    else $error("phase overflow away from bottom");

  ovf_ctc_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tick_i && !wr_count && waveform_mode_sel_i == WGM_CTC && at_max) |-> ovf_evt)
    else $error("ctc overflow missed at max");

  ovf_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_count |-> !ovf_evt)
    else $error("overflow during count write");

  evt_tick_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (match_a_evt || match_b_evt || ovf_evt) |-> tick_i)
    else $error("event without tick");

  match_a_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    match_a_evt |=> match_a_o)
    else $error("match a pulse missing");

  match_a_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !match_a_evt |=> !match_a_o)
    else $error("match a pulse spurious");

  match_b_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    match_b_evt |=> match_b_o)
    else $error("match b pulse missing");

  match_b_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !match_b_evt |=> !match_b_o)
    else $error("match b pulse spurious");

  block_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_count |=> block_match)
    else $error("block not armed");

  block_end_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (block_match && tick_i && !wr_count) |=> !block_match)
    else $error("block outlived tick");

  cmp_a_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.wr && sel_cmp_a) |=> compare_value_a == $past(bus_i.wdata))
    else $error("compare a not loaded");

  cmp_b_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.wr && sel_cmp_b) |=> compare_value_b == $past(bus_i.wdata))
    else $error("compare b not loaded");

  mask_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.wr && sel_mask) |=> timer_mask_register == $past(bus_i.wdata[2:0]))
    else $error("mask not loaded");

  read_count_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.rd && sel_count) |=> rdata_o == $past(counter_value))
    else $error("count read wrong");

  read_cmpa_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.rd && sel_cmp_a) |=> rdata_o == $past(compare_value_a))
    else $error("compare a read wrong");

  read_cmpb_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.rd && sel_cmp_b) |=> rdata_o == $past(compare_value_b))
    else $error("compare b read wrong");

  read_flags_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.rd && sel_flags) |=> rdata_o == {5'h00, $past(timer_flag_register)})
    else $error("flag read wrong");

  read_mask_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.rd && sel_mask) |=> rdata_o == {5'h00, $past(timer_mask_register)})
    else $error("mask read wrong");

  read_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !bus_i.rd |=> rdata_o == RESET_VALUE)
    else $error("read data without read");

  read_unmapped_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.rd && !(sel_flags || sel_count || sel_cmp_a || sel_cmp_b || sel_mask)) |=> rdata_o == RESET_VALUE)
    else $error("unmapped read not zero");

  io_window_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!bus_i.data_space && bus_i.addr >= (IO_OFFSET + IO_OFFSET)) |-> !acc_ok)
    else $error("io access outside window");

  ext_refuse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!bus_i.data_space && eff_addr >= EXT_IO_BASE) |-> !acc_ok)
    else $error("io access to extended space");

  gie_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !global_int_enable_i |=> int_req_o == 3'h0)
    else $error("request with global enable off");

  force_a_wave_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (force_match_a_strobe_i && non_pwm && !match_a_evt) |=> wave_out_a_o != $past(wave_out_a_o))
    else $error("force a did not toggle");

  force_b_wave_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (force_match_b_strobe_i && non_pwm && !match_b_evt) |=> wave_out_b_o != $past(wave_out_b_o))
    else $error("force b did not toggle");

  force_pwm_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (force_match_a_strobe_i && !non_pwm && !match_a_evt) |=> $stable(wave_out_a_o))
    else $error("force acted in pwm mode");

  force_a_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (force_match_a_strobe_i && !match_a_evt) |=> !$rose(timer_flag_register[BIT_MATCH_A]))
    else $error("force set a flag");

  wave_a_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !tog_a |=> $stable(wave_out_a_o))
    else $error("wave a moved alone");

  wave_b_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !tog_b |=> $stable(wave_out_b_o))
    else $error("wave b moved alone");
endmodule : t8_core
`default_nettype wire

// ---- bench/t8_cpu_model.sv ----
// processor-side bus master model for the timer core
`timescale 1ns/100ps
`default_nettype none
module t8_cpu_model (
  input wire logic clk_sys_i,
  output var t8_pkg::t8_bus_t bus_o
);
  import t8_pkg::*;
  initial bus_o = '0;
  // callers pass data-space offsets; io form is offset minus the io shift
  task automatic acc(input logic w, input logic ds, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    bus_o <= '{ds, ds ? a : a - IO_OFFSET, w, !w, v};
    @(posedge clk_sys_i);
    bus_o <= '{1'b0, ~a, 1'b0, 1'b0, ~v};
  endtask : acc
endmodule : t8_cpu_model
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the timer core
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import t8_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic tick = 1'b0;
  logic frc = 1'b0;
  logic gie = 1'b0;
  logic [2:0] ack = 3'h0;
  logic [7:0] rdata;
  logic [2:0] irq;
  logic wave_a;
  t8_wgm_t mode = WGM_NORMAL;
  logic rd_seen = 1'b0;
  logic [7:0] v;
  logic [7:0] adr [5] = '{ADDR_FLAGS, ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B, ADDR_MASK};
  int seed = 32'h25af34b7;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] exp_q [$];
  t8_bus_t bus;
  t8_cpu_model t8_cpu_model_i (.clk_sys_i(clk_sys_i), .bus_o(bus));
  t8_core t8_core_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus), .tick_i(tick),
    .waveform_mode_sel_i(mode), .force_match_a_strobe_i(frc), .force_match_b_strobe_i(1'b0),
    .global_int_enable_i(gie), .int_ack_i(ack), .rdata_o(rdata), .int_req_o(irq), .match_a_o(),
    .match_b_o(), .wave_out_a_o(wave_a), .wave_out_b_o());
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic wr(input logic ds, input logic [7:0] a, input logic [7:0] d);
    t8_cpu_model_i.acc(1'b1, ds, a, d);
  endtask : wr
  // expectation noted before the strobe goes out
  task automatic rd(input logic ds, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    t8_cpu_model_i.acc(1'b0, ds, a, ~e);
  endtask : rd
  task automatic step();
    @(posedge clk_sys_i);
    tick <= 1'b1;
    @(posedge clk_sys_i);
    tick <= 1'b0;
  endtask : step
  // read data stands one cycle only, so look at the falling edge
  always @(posedge clk_sys_i) rd_seen <= bus.rd;
  always @(negedge clk_sys_i) begin
    if (rd_seen && exp_q.size() > 0) cmp(rdata, exp_q.pop_front());
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) rd(1'b1, adr[i], RESET_VALUE);
    v = 8'($random(seed));
    wr(1'b0, ADDR_CMP_A, v);
    rd(1'b1, ADDR_CMP_A, v);
    wr(1'b1, ADDR_CMP_B, ~v);
    rd(1'b0, ADDR_CMP_B, ~v);
    wr(1'b0, ADDR_MASK, 8'h07);
    rd(1'b1, ADDR_MASK, 8'h00);
    wr(1'b1, ADDR_MASK, 8'h07);
    rd(1'b1, ADDR_MASK, 8'h07);
    wr(1'b1, ADDR_CMP_A, 8'h05);
    wr(1'b1, ADDR_CMP_B, 8'h06);
    wr(1'b0, ADDR_COUNT, 8'h05);
    step();
    step();
    rd(1'b0, ADDR_FLAGS, 8'h04);
    rd(1'b1, ADDR_COUNT, 8'h07);
    @(negedge clk_sys_i);
    cmp({5'h00, irq}, 8'h00);
    wr(1'b1, ADDR_FLAGS, 8'h00);
    rd(1'b1, ADDR_FLAGS, 8'h04);
    wr(1'b0, ADDR_FLAGS, 8'h04);
    rd(1'b0, ADDR_FLAGS, 8'h00);
    @(posedge clk_sys_i);
    frc <= 1'b1;
    @(posedge clk_sys_i);
    frc <= 1'b0;
    rd(1'b1, ADDR_FLAGS, 8'h00);
    @(negedge clk_sys_i);
    cmp({7'h00, wave_a}, 8'h01);
    gie <= 1'b1;
    wr(1'b1, ADDR_COUNT, 8'h04);
    step();
    step();
    @(negedge clk_sys_i);
    cmp({5'h00, irq}, 8'h02);
    @(posedge clk_sys_i);
    ack <= 3'h2;
    @(posedge clk_sys_i);
    ack <= 3'h0;
    rd(1'b1, ADDR_FLAGS, 8'h00);
    wr(1'b1, ADDR_COUNT, 8'hFE);
    step();
    step();
    @(negedge clk_sys_i);
    cmp({5'h00, irq}, 8'h01);
    rd(1'b1, ADDR_FLAGS, 8'h01);
    wr(1'b1, ADDR_FLAGS, 8'h07);
    mode <= WGM_CTC;
    wr(1'b1, ADDR_COUNT, 8'h04);
    step();
    step();
    rd(1'b1, ADDR_COUNT, 8'h00);
    rd(1'b1, ADDR_FLAGS, 8'h02);
    repeat (2) @(posedge clk_sys_i);
    stop_test();
  end
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
